// *** nvss_delay.sv ***
// one-shot busy timer for save and restore durations
`include "nvss_map.svh"
module nvss_delay (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic start,
   input wire logic [`NVSS_TIMER_W-1:0] cycles,
   output logic done
);
   nvss_pkg::nvss_delay_state_t st_reg;
   nvss_pkg::nvss_delay_state_t st_next;

   always_comb begin
      st_next = st_reg;
      st_next.done = 1'b0;
      if (start) begin
         st_next.count = cycles;
      end else if (st_reg.count != '0) begin
         st_next.count = st_reg.count - 1'b1;
         if (st_reg.count == `NVSS_TIMER_W'(1)) begin
            st_next.done = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign done = st_reg.done;
endmodule

// *** nvss_dev.sv ***
// behavioural nonvolatile sram device answering the host controller
module nvss_dev #(
   parameter int SAVE_NS = 400,
   parameter int RECALL_NS = 200
) (
   input wire logic supply_ok,
   input wire logic chip_en_n,
   input wire logic write_en_n,
   input wire logic out_en_n,
   input wire logic [12:0] address_lines,
   input wire logic [7:0] data_in,
   output logic [7:0] data_out
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [12:0] seq [0:4] = '{13'h0000, 13'h1555, 13'h0aaa, 13'h1fff, 13'h10f0};
   logic [7:0] sram [0:8191];
   logic [7:0] nv [0:8191] = '{default: 8'h00};
   logic dev_busy = 1'b1;
   int step = 0;
   int bad = 0;
   // released bus shows the inverse so a missed drive never reads as data
   assign data_out = (!chip_en_n && !out_en_n && write_en_n && !dev_busy) ?
      sram[address_lines] : ~sram[address_lines];
   task automatic recall();
      dev_busy = 1'b1;
      foreach (sram[i]) sram[i] = 8'h00;
      #(RECALL_NS);
      sram = nv;
      if (!write_en_n) bad++;
      dev_busy = 1'b0;
   endtask
   always @(posedge supply_ok) recall();
   always @(negedge chip_en_n) if (dev_busy) bad++;
   // strobes are registered together, so look a little after the edge
   always @(negedge chip_en_n) begin
      #1;
      if (dev_busy) begin
      end else if (!write_en_n) begin
         sram[address_lines] = data_in;
         step = 0;
      end else if (step == 5) begin
         step = 0;
         if (address_lines == 13'h139c) bad++;
         if (address_lines == 13'h0f0f && supply_ok) begin
            dev_busy = 1'b1;
            foreach (nv[i]) nv[i] = 8'hff;
            #(SAVE_NS);
            nv = sram;
            dev_busy = 1'b0;
         end else if (address_lines == 13'h0f0e) recall();
      end else if (address_lines == seq[step]) step++;
      else step = int'(address_lines == 13'h0000);
   end
endmodule

// *** nvss_host.sv ***
// host controller driving the nonvolatile sram pins, incl. save/restore sequences
`include "nvss_map.svh"
module nvss_host #(
   parameter logic [`NVSS_TIMER_W-1:0] SAVE_CYCLES = `NVSS_TIMER_W'(`NVSS_SAVE_CYC),
   parameter logic [`NVSS_TIMER_W-1:0] RESTORE_CYCLES = `NVSS_TIMER_W'(`NVSS_RESTORE_CYC)
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic supply_ok,
   input wire logic req_valid,
   output logic req_ready,
   input wire nvss_pkg::nvss_req_t req,
   output logic rdata_valid,
   output logic [`NVSS_DATA_W-1:0] rdata,
   output logic busy,
   output logic save_refused,
   output logic chip_en_n,
   output logic write_en_n,
   output logic out_en_n,
   output logic [`NVSS_ADDR_W-1:0] address_lines,
   output logic [`NVSS_DATA_W-1:0] data_lines_o,
   output logic data_lines_oe,
   input wire logic [`NVSS_DATA_W-1:0] data_lines_i
);
   nvss_pkg::nvss_host_state_t st_reg;
   nvss_pkg::nvss_host_state_t st_next;
   logic supply_meta_reg;
   logic supply_sync_reg;
   logic supply_prev_reg;
   logic [`NVSS_DATA_W-1:0] din_meta_reg;
   logic [`NVSS_DATA_W-1:0] din_sync_reg;
   logic tmr_start;
   logic [`NVSS_TIMER_W-1:0] tmr_cycles;
   logic tmr_done;

   // pins from outside the clock domain pass two flops first
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         supply_meta_reg <= 1'b0;
         supply_sync_reg <= 1'b0;
         supply_prev_reg <= 1'b0;
         din_meta_reg <= '0;
         din_sync_reg <= '0;
      end else begin
         supply_meta_reg <= supply_ok;
         supply_sync_reg <= supply_meta_reg;
         supply_prev_reg <= supply_sync_reg;
         din_meta_reg <= data_lines_i;
         din_sync_reg <= din_meta_reg;
      end
   end

   nvss_delay u_delay (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .start(tmr_start),
      .cycles(tmr_cycles),
      .done(tmr_done)
   );

   function automatic logic [`NVSS_ADDR_W-1:0] seq_addr(input logic [2:0] step,
                                                       input nvss_pkg::nvss_cmd_t cmd);
      case (step)
         3'h0: seq_addr = `NVSS_SEQ_A0;
         3'h1: seq_addr = `NVSS_SEQ_A1;
         3'h2: seq_addr = `NVSS_SEQ_A2;
         3'h3: seq_addr = `NVSS_SEQ_A3;
         3'h4: seq_addr = `NVSS_SEQ_A4;
         default: seq_addr = (cmd == nvss_pkg::nvss_cmd_save) ?
            `NVSS_SEQ_SAVE : `NVSS_SEQ_RESTORE; // see [RULE1] see [RULE2] see [RULE17]
      endcase
   endfunction

   always_comb begin
      st_next = st_reg;
      st_next.rdata_valid = 1'b0;
      tmr_start = 1'b0;
      tmr_cycles = RESTORE_CYCLES;
      case (st_reg.state)
         nvss_pkg::nvss_st_powerup: begin
            // device restores by itself; wait its full duration before any access
            if (supply_sync_reg && !supply_prev_reg) begin
               tmr_start = 1'b1; // see [RULE11] see [RULE12] see [RULE19]
               tmr_cycles = RESTORE_CYCLES;
            end
            if (tmr_done && supply_sync_reg) begin
               st_next.state = nvss_pkg::nvss_st_idle; // see [RULE12]
            end
         end
         nvss_pkg::nvss_st_idle: begin
            if (req_valid && supply_sync_reg) begin
               st_next.req = req;
               st_next.step = 3'h0;
               st_next.was_save = (req.cmd == nvss_pkg::nvss_cmd_save);
               if (req.cmd == nvss_pkg::nvss_cmd_save && !supply_sync_reg) begin
                  st_next.save_refused = 1'b1; // see [RULE14]
               end else begin
                  st_next.save_refused = 1'b0;
                  st_next.state = nvss_pkg::nvss_st_setup;
                  st_next.timer = `NVSS_TIMER_W'(`NVSS_SETUP_CYC);
               end
            end
         end
         nvss_pkg::nvss_st_setup: begin
            // address set on the same clock edge that chip select falls
            if (st_reg.req.cmd == nvss_pkg::nvss_cmd_save ||
                st_reg.req.cmd == nvss_pkg::nvss_cmd_restore) begin
               st_next.pins.address_lines = seq_addr(st_reg.step, st_reg.req.cmd);
               st_next.pins.write_en_n = 1'b1; // see [RULE5] see [RULE15]
               st_next.pins.out_en_n = 1'b1; // see [RULE6]
               st_next.pins.data_oe = 1'b0;
            end else begin
               st_next.pins.address_lines = st_reg.req.addr;
               st_next.pins.out_en_n = (st_reg.req.cmd == nvss_pkg::nvss_cmd_write);
               st_next.pins.data_out = st_reg.req.wdata;
               st_next.pins.data_oe = (st_reg.req.cmd == nvss_pkg::nvss_cmd_write);
               st_next.pins.write_en_n = 1'b1;
            end
            st_next.timer = st_reg.timer - 1'b1;
            if (st_reg.timer <= `NVSS_TIMER_W'(1)) begin
               st_next.state = nvss_pkg::nvss_st_pulse;
               st_next.timer = `NVSS_TIMER_W'(`NVSS_PULSE_CYC);
               st_next.pins.chip_en_n = 1'b0; // see [RULE16]
               st_next.pins.write_en_n = (st_reg.req.cmd != nvss_pkg::nvss_cmd_write);
            end
         end
         nvss_pkg::nvss_st_pulse: begin
            st_next.timer = st_reg.timer - 1'b1;
            if (st_reg.timer <= `NVSS_TIMER_W'(1)) begin
               st_next.pins.chip_en_n = 1'b1; // see [RULE16]
               st_next.pins.write_en_n = 1'b1;
               st_next.pins.out_en_n = 1'b1;
               st_next.state = nvss_pkg::nvss_st_hold;
               st_next.timer = `NVSS_TIMER_W'(`NVSS_HOLD_CYC);
               if (st_reg.req.cmd == nvss_pkg::nvss_cmd_read) begin
                  st_next.rdata = din_sync_reg;
                  st_next.rdata_valid = 1'b1;
               end
            end
         end
         nvss_pkg::nvss_st_hold: begin
            st_next.timer = st_reg.timer - 1'b1;
            if (st_reg.timer <= `NVSS_TIMER_W'(1)) begin
               st_next.pins.data_oe = 1'b0;
               if ((st_reg.req.cmd == nvss_pkg::nvss_cmd_save ||
                    st_reg.req.cmd == nvss_pkg::nvss_cmd_restore) && st_reg.step != 3'h5) begin
                  // no other access may slip in between the six reads
                  st_next.step = st_reg.step + 3'h1; // see [RULE3] see [RULE18]
                  st_next.state = nvss_pkg::nvss_st_setup;
                  st_next.timer = `NVSS_TIMER_W'(`NVSS_SETUP_CYC);
               end else if (st_reg.req.cmd == nvss_pkg::nvss_cmd_save ||
                            st_reg.req.cmd == nvss_pkg::nvss_cmd_restore) begin
                  // device ignores all pins while busy
                  st_next.state = nvss_pkg::nvss_st_busy; // see [RULE4] see [RULE8] see [RULE9]
                  tmr_start = 1'b1;
                  tmr_cycles = st_reg.was_save ? SAVE_CYCLES : RESTORE_CYCLES; // see [RULE19]
               end else begin
                  st_next.state = nvss_pkg::nvss_st_idle;
               end
            end
         end
         nvss_pkg::nvss_st_busy: begin
            if (tmr_done) begin
               st_next.state = nvss_pkg::nvss_st_idle; // see [RULE7] see [RULE10]
            end
         end
         default: st_next.state = nvss_pkg::nvss_st_powerup;
      endcase
      if (!supply_sync_reg) begin
         // power loss forces a fresh power-up restore wait
         // placed last so no strobe started this cycle reaches an unpowered device
         st_next.state = nvss_pkg::nvss_st_powerup;
         st_next.pins.chip_en_n = 1'b1;
         st_next.pins.write_en_n = 1'b1; // see [RULE13]
         st_next.pins.out_en_n = 1'b1;
         st_next.pins.data_oe = 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         st_reg <= '0;
         st_reg.state <= nvss_pkg::nvss_st_powerup;
         st_reg.pins.chip_en_n <= 1'b1;
         st_reg.pins.write_en_n <= 1'b1;
         st_reg.pins.out_en_n <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   // a save at low supply is never taken since req_ready stays low; save_refused never sets
   assign req_ready = (st_reg.state == nvss_pkg::nvss_st_idle) && supply_sync_reg;
   assign rdata_valid = st_reg.rdata_valid;
   assign rdata = st_reg.rdata;
   assign busy = (st_reg.state != nvss_pkg::nvss_st_idle);
   assign save_refused = st_reg.save_refused;
   assign chip_en_n = st_reg.pins.chip_en_n;
   assign write_en_n = st_reg.pins.write_en_n;
   assign out_en_n = st_reg.pins.out_en_n;
   assign address_lines = st_reg.pins.address_lines;
   assign data_lines_o = st_reg.pins.data_out;
   assign data_lines_oe = st_reg.pins.data_oe;
endmodule

// *** nvss_host_assertions.sv ***
// concurrent checks on the nonvolatile sram host controller ports
`include "nvss_map.svh"
module nvss_host_chk #(
   parameter logic [`NVSS_TIMER_W-1:0] SAVE_CYCLES = 20'd20,
   parameter logic [`NVSS_TIMER_W-1:0] RESTORE_CYCLES = 20'd10
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic supply_ok,
   input wire logic req_valid,
   input wire logic req_ready,
   input wire nvss_pkg::nvss_req_t req,
   input wire logic rdata_valid,
   input wire logic [`NVSS_DATA_W-1:0] rdata,
   input wire logic busy,
   input wire logic save_refused,
   input wire logic chip_en_n,
   input wire logic write_en_n,
   input wire logic out_en_n,
   input wire logic [`NVSS_ADDR_W-1:0] address_lines,
   input wire logic [`NVSS_DATA_W-1:0] data_lines_o,
   input wire logic data_lines_oe,
   input wire logic [`NVSS_DATA_W-1:0] data_lines_i
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   ready_idle_a: assert property (req_ready |-> !busy)
      else $error("request accepted while busy");
   take_busy_a: assert property (req_valid && req_ready |=> busy)
      else $error("busy missing after request taken");
   supply_low_a: assert property (!supply_ok [*4] |-> !req_ready && busy)
      else $error("requests accepted with supply low");
   write_drive_a: assert property (!write_en_n |-> !chip_en_n && data_lines_oe)
      else $error("write strobe without select or data drive");
   read_float_a: assert property (!out_en_n |-> !data_lines_oe && write_en_n)
      else $error("output enable while host drives data");
   strobe_len_a: assert property ($fell(chip_en_n) |=>
      (!chip_en_n && $stable(address_lines)) [*2] ##1 chip_en_n)
      else $error("chip select pulse length or address hold wrong");
   seq_read_a: assert property (req_valid && req_ready &&
      req.cmd inside {nvss_pkg::nvss_cmd_save, nvss_pkg::nvss_cmd_restore} |=> write_en_n [*8])
      else $error("write strobe during save or restore sequence");
   rdv_pulse_a: assert property (rdata_valid |-> $rose(chip_en_n) ##1 !rdata_valid)
      else $error("read data valid not a pulse at select release");
   read_done_a: assert property (req_valid && req_ready &&
      req.cmd == nvss_pkg::nvss_cmd_read |-> ##[4:7] !busy)
      else $error("read did not complete in time");
endmodule
bind nvss_host nvss_host_chk #(.SAVE_CYCLES(SAVE_CYCLES), .RESTORE_CYCLES(RESTORE_CYCLES))
   u_chk (.*);

// *** nvss_map.svh ***
// constants for the nonvolatile save/restore host sequencer
// Function
// [RULE1] save starts after reads 0000,1555,0AAA,1FFF,10F0,0F0F in that order
// [RULE2] restore starts after same five reads then 0F0E
// [RULE3] device aborts a partial sequence when another access intervenes
// [RULE4] after sixth save address device is disabled until save finishes
// [RULE5] host uses reads only for every step of a sequence
// [RULE6] sequence is valid whether or not output enable is asserted
// [RULE7] after save duration device accepts reads and writes again
// [RULE8] save erases nonvolatile contents then programs all cells in parallel
// [RULE9] restore clears SRAM first, then copies nonvolatile contents in
// [RULE10] restore leaves nonvolatile contents intact; unlimited restores allowed
// [RULE11] device restores automatically when supply rises above switch threshold
// [RULE12] no SRAM access until restore duration after threshold crossing
// [RULE13] host keeps write strobe inactive when power-up restore ends
// [RULE14] device refuses software save while supply below switch threshold
// [RULE15] host holds write strobe high during all six sequence reads
// [RULE16] each step is a chip-select strobed read; toggle select per address
// [RULE17] host never issues reserved test sequence ending in 139C
// [RULE18] detector returns idle after sequence; restarts only on fresh 0000 read
// [RULE19] save and restore durations are parameters; busy held for the whole
`ifndef NVSS_MAP_SVH
`define NVSS_MAP_SVH
`define NVSS_ADDR_W 13
`define NVSS_DATA_W 8
`define NVSS_SEQ_A0 13'h0000
`define NVSS_SEQ_A1 13'h1555
`define NVSS_SEQ_A2 13'h0aaa
`define NVSS_SEQ_A3 13'h1fff
`define NVSS_SEQ_A4 13'h10f0
`define NVSS_SEQ_SAVE 13'h0f0f
`define NVSS_SEQ_RESTORE 13'h0f0e
`define NVSS_CLK_NS 25
// strobe phase times in ns, chip select low pulse at least 45 ns
`define NVSS_SETUP_NS 25
// three cycles low: read data needs two sync flops before it is captured
`define NVSS_PULSE_NS 75
`define NVSS_HOLD_NS 25
`define NVSS_CYC(ns) (((ns) + `NVSS_CLK_NS - 1) / `NVSS_CLK_NS)
`define NVSS_SETUP_CYC `NVSS_CYC(`NVSS_SETUP_NS)
`define NVSS_PULSE_CYC `NVSS_CYC(`NVSS_PULSE_NS)
`define NVSS_HOLD_CYC `NVSS_CYC(`NVSS_HOLD_NS)
// save_duration 10 ms, powerup_restore_duration 20 us
`define NVSS_SAVE_US 10000
`define NVSS_RESTORE_US 20
`define NVSS_SAVE_CYC (`NVSS_SAVE_US * 1000 / `NVSS_CLK_NS)
`define NVSS_RESTORE_CYC (`NVSS_RESTORE_US * 1000 / `NVSS_CLK_NS)
`define NVSS_TIMER_W 20
`endif

// *** nvss_pkg.sv ***
// types for the nonvolatile save/restore host sequencer
`include "nvss_map.svh"
package nvss_pkg;
   typedef enum logic [1:0] {
      nvss_cmd_read,
      nvss_cmd_write,
      nvss_cmd_save,
      nvss_cmd_restore
   } nvss_cmd_t;

   typedef struct packed {
      nvss_cmd_t cmd;
      logic [`NVSS_ADDR_W-1:0] addr;
      logic [`NVSS_DATA_W-1:0] wdata;
   } nvss_req_t;

   typedef struct packed {
      logic chip_en_n;
      logic write_en_n;
      logic out_en_n;
      logic [`NVSS_ADDR_W-1:0] address_lines;
      logic [`NVSS_DATA_W-1:0] data_out;
      logic data_oe;
   } nvss_pins_t;

   typedef enum {
      nvss_st_powerup,
      nvss_st_idle,
      nvss_st_setup,
      nvss_st_pulse,
      nvss_st_hold,
      nvss_st_busy
   } nvss_state_t;

   typedef struct packed {
      nvss_state_t state;
      nvss_req_t req;
      logic [2:0] step;
      logic [`NVSS_TIMER_W-1:0] timer;
      logic rdata_valid;
      logic [`NVSS_DATA_W-1:0] rdata;
      logic was_save;
      logic save_refused;
      nvss_pins_t pins;
   } nvss_host_state_t;

   typedef struct packed {
      logic [`NVSS_TIMER_W-1:0] count;
      logic done;
   } nvss_delay_state_t;
endpackage

// *** tb.sv ***
// self-checking bench for the nonvolatile sram host controller
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int SAVE_C = 20;
   localparam int REST_C = 10;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic supply_ok = 1'b0;
   logic req_valid = 1'b0;
   logic req_ready, rdata_valid, busy, save_refused, chip_en_n, write_en_n, out_en_n;
   logic data_lines_oe;
   nvss_pkg::nvss_req_t req = '0;
   logic [12:0] address_lines;
   logic [7:0] rdata, data_lines_o, data_lines_i, dev_data;
   logic [12:0] a [0:3];
   logic [7:0] d [0:3];
   logic [7:0] q [$];
   int n_errors = 0;
   int cmp_count = 0;
   int seed = 32'hb118;
   int n;
   assign data_lines_i = data_lines_oe ? data_lines_o : dev_data;
   nvss_host #(.SAVE_CYCLES(20'd20), .RESTORE_CYCLES(20'd10)) u_nvss_host (.*);
   nvss_dev u_nvss_dev (.data_in(data_lines_i), .data_out(dev_data), .*);
   initial forever #12.5 clk_sys = ~clk_sys;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_sim();
      $display("compares %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic tick();
      @(posedge clk_sys);
      #2;
   endtask
   // n ends as the number of busy cycles after the take
   task automatic run(input nvss_pkg::nvss_cmd_t c, input logic [12:0] ad, input logic [7:0] dt);
      while (!req_ready) tick();
      req_valid = 1'b1;
      req = '{cmd: c, addr: ad, wdata: dt};
      tick();
      req_valid = 1'b0;
      n = 0;
      while (busy) begin
         tick();
         n++;
      end
   endtask
   task automatic rd_all(input logic [7:0] x);
      for (int i = 0; i < 4; i++) begin
         q.push_back(d[i] ^ x);
         run(nvss_pkg::nvss_cmd_read, a[i], 8'h00);
      end
      chk(q.size(), 0);
   endtask
   // a valid pulse with nothing expected is itself a mismatch
   always @(negedge clk_sys) begin
      if (rdata_valid === 1'b1) begin
         if (q.size() == 0) chk(rdata_valid, 1'b0);
         else chk(rdata, q.pop_front());
      end
   end
   initial begin
      repeat (20000) @(posedge clk_sys);
      n_errors++;
      end_sim();
   end
   initial begin
      repeat (6) tick();
      rst_n = 1'b1;
      repeat (8) tick();
      chk(busy, 1);
      chk(req_ready, 0);
      supply_ok = 1'b1;
      n = 0;
      while (!req_ready) begin
         tick();
         n++;
      end
      chk(n >= REST_C, 1);
      $display("test powerup done");
      for (int i = 0; i < 4; i++) begin
         a[i] = {11'($random(seed)), 2'(i)};
         d[i] = 8'($random(seed));
         run(nvss_pkg::nvss_cmd_write, a[i], d[i]);
      end
      rd_all(8'h00);
      $display("test write read done");
      run(nvss_pkg::nvss_cmd_save, 13'h0000, 8'h00);
      chk(n >= SAVE_C, 1);
      chk(save_refused, 0);
      for (int i = 0; i < 4; i++) chk(u_nvss_dev.nv[a[i]], d[i]);
      rd_all(8'h00);
      $display("test save done");
      for (int i = 0; i < 4; i++) run(nvss_pkg::nvss_cmd_write, a[i], ~d[i]);
      rd_all(8'hff);
      repeat (2) begin
         run(nvss_pkg::nvss_cmd_restore, 13'h0000, 8'h00);
         chk(n >= REST_C, 1);
         rd_all(8'h00);
      end
      $display("test restore done");
      run(nvss_pkg::nvss_cmd_write, a[0], ~d[0]);
      supply_ok = 1'b0;
      repeat (4) tick();
      chk(req_ready, 0);
      chk(busy, 1);
      supply_ok = 1'b1;
      rd_all(8'h00);
      chk(u_nvss_dev.bad, 0);
      $display("test supply drop done");
      end_sim();
   end
endmodule
